// file: adcr_pkg.sv
/*
  Package for the converter control and result unit: register indices,
  field positions, reset values, channel codes and timing counts.
  Assumes a plain register port with 8-bit data and one 100 MHz clock.
*/
package adcr_pkg;
  // Register offsets on the plain register port
  localparam logic [2:0] ADDR_STATUS_CONTROL = 3'h0;
  localparam logic [2:0] ADDR_RESULT_HIGH = 3'h1;
  localparam logic [2:0] ADDR_RESULT_LOW = 3'h2;
  localparam logic [2:0] ADDR_PIN_ENABLE = 3'h3;
  localparam logic [2:0] ADDR_CONTROL = 3'h4;
  // Status/control field positions
  localparam int DONE_BIT = 7;
  localparam int IRQ_EN_BIT = 6;
  localparam int CONT_BIT = 5;
  // Control register field positions
  localparam int EIGHT_BIT_POS = 6;
  localparam int JUSTIFY_POS = 5;
  localparam int SIGNED_POS = 4;
  // Reset values
  localparam logic [7:0] STATUS_CONTROL_RST = 8'h1f;
  localparam logic [7:0] PIN_ENABLE_RST = 8'h00;
  localparam logic [7:0] CONTROL_RST = 8'h00;
  // Channel codes
  localparam logic [4:0] CHAN_LAST_PIN = 5'h07;
  localparam logic [4:0] CHAN_REF_HIGH = 5'h1e;
  // Mux selector driven to the analog core
  localparam logic [1:0] MUX_PIN = 2'h0;
  localparam logic [1:0] MUX_REF_LOW = 2'h1;
  localparam logic [1:0] MUX_REF_HIGH = 2'h2;
  // Conversion length in conversion-clock cycles
  localparam logic [4:0] CONV_CYCLES = 5'h14;
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_CONVERT
  } adcr_state_t;
endpackage

// file: adcr_prescaler.sv
/*
  Conversion clock prescaler: emits one tick per conversion-clock period,
  which is the bus clock divided by (prescale_field + 1) * 2.
  Assumes the caller holds restart high when a conversion begins.
*/
`timescale 1ns/1ps
module adcr_prescaler
  import adcr_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Control
  input wire logic restart,
  input wire logic [3:0] prescale_field,
  // Tick, one bus cycle per conversion-clock period
  output logic tick
);
  logic [4:0] count_r;
  logic [4:0] limit;

  // Period in bus cycles minus one
  assign limit = {prescale_field, 1'b1};
  assign tick = !restart && (count_r == limit);

  // Period counter
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count_r <= 5'h00;
    end else if (restart || count_r == limit) begin
      count_r <= 5'h00;
    end else begin
      count_r <= count_r + 5'h01;
    end
  end
endmodule

// file: adcr_top.sv
/*
  Control and result unit of a 10-bit converter: status/control, result,
  pin-enable and control registers, channel steering, conversion sequencing.
  Assumes an analog core that samples on conv_sample and presents a
  10-bit code that is stable by the end of the conversion interval.
*/
`timescale 1ns/1ps
module adcr_top
  import adcr_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register port
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Interrupt request
  output logic conv_irq,
  // Analog core
  output logic conv_sample,
  output logic [1:0] conv_mux_sel,
  output logic [2:0] conv_pin_sel,
  input wire logic [9:0] conv_code
);
  logic [7:0] conv_status_control_r;
  logic [7:0] conv_pin_enable_r;
  logic [7:0] conv_control_reg_r;
  logic [7:0] conv_result_high_r;
  logic [7:0] conv_result_low_r;
  logic conversion_done_flag_r;
  adcr_state_t state_r;
  logic [4:0] cycle_r;
  logic [9:0] code_sync1_r;
  logic [9:0] code_sync2_r;
  logic tick;
  logic sc_write;
  logic pe_write;
  logic result_read;
  logic conv_end;
  logic [4:0] channel_select_field;
  logic pin_enable_bit;
  logic eight_bit_select;
  logic justify_select;
  logic signed_select;
  logic [9:0] code_eff;
  logic [7:0] high_nxt;
  logic [7:0] low_nxt;

  // Decoded strobes
  assign sc_write = reg_wr && (reg_addr == ADDR_STATUS_CONTROL);
  assign pe_write = reg_wr && (reg_addr == ADDR_PIN_ENABLE);
  assign result_read = reg_rd && (reg_addr == ADDR_RESULT_HIGH || reg_addr == ADDR_RESULT_LOW);
  assign channel_select_field = conv_status_control_r[4:0];
  assign eight_bit_select = conv_control_reg_r[EIGHT_BIT_POS];
  assign justify_select = conv_control_reg_r[JUSTIFY_POS];
  assign signed_select = conv_control_reg_r[SIGNED_POS];
  assign pin_enable_bit = conv_pin_enable_r[channel_select_field[2:0]];
  assign conv_end = (state_r == ST_CONVERT) && tick && (cycle_r == CONV_CYCLES - 5'h01);

  // Conversion clock divider
  adcr_prescaler u_prescaler (
    .clk(clk),
    .rst(rst),
    .restart(sc_write || pe_write || state_r == ST_IDLE),
    .prescale_field(conv_control_reg_r[3:0]),
    .tick(tick)
  );

  // Channel steering to the analog mux
  always_comb begin
    conv_pin_sel = channel_select_field[2:0];
    if (channel_select_field == CHAN_REF_HIGH) begin
      conv_mux_sel = MUX_REF_HIGH;
    end else if (channel_select_field > CHAN_LAST_PIN) begin
      conv_mux_sel = MUX_REF_LOW;
    end else if (!pin_enable_bit) begin
      conv_mux_sel = MUX_REF_LOW;
    end else begin
      conv_mux_sel = MUX_PIN;
    end
  end

  // Sample pulse at the start of every conversion
  assign conv_sample = (state_r == ST_CONVERT) && (cycle_r == 5'h00) && tick;

  // Core code arrives from the analog side, so it is resynchronised
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      code_sync1_r <= 10'h000;
      code_sync2_r <= 10'h000;
    end else begin
      code_sync1_r <= conv_code;
      code_sync2_r <= code_sync1_r;
    end
  end

  // Low reference always yields zero, whatever the core reports
  assign code_eff = (conv_mux_sel == MUX_REF_LOW) ? 10'h000 : code_sync2_r;

  // Result formatting
  always_comb begin
    high_nxt = 8'h00;
    low_nxt = 8'h00;
    if (eight_bit_select) begin
      high_nxt = code_eff[9:2];
      if (!justify_select && signed_select) begin
        high_nxt[7] = ~code_eff[9];
      end
    end else if (justify_select) begin
      high_nxt = {6'h00, code_eff[9:8]};
      low_nxt = code_eff[7:0];
    end else begin
      high_nxt = code_eff[9:2];
      low_nxt = {code_eff[1:0], 6'h00};
      if (signed_select) begin
        high_nxt[7] = ~code_eff[9];
      end
    end
  end

  // Status/control: software fields; done flag kept separately
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      conv_status_control_r <= STATUS_CONTROL_RST;
    end else if (sc_write) begin
      conv_status_control_r <= {1'b0, reg_wdata[6:0]};
    end
  end

  // Pin enables
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      conv_pin_enable_r <= PIN_ENABLE_RST;
    end else if (pe_write) begin
      conv_pin_enable_r <= reg_wdata;
    end
  end

  // Control register: resolution, justification, sign, prescale
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      conv_control_reg_r <= CONTROL_RST;
    end else if (reg_wr && reg_addr == ADDR_CONTROL) begin
      conv_control_reg_r <= reg_wdata;
    end
  end

  // Sequencer: write starts, pin-enable write aborts, continuous repeats
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r <= ST_IDLE;
      cycle_r <= 5'h00;
    end else if (sc_write) begin
      state_r <= ST_CONVERT;
      cycle_r <= 5'h00;
    end else if (pe_write) begin
      state_r <= ST_IDLE;
      cycle_r <= 5'h00;
    end else begin
      case (state_r)
        ST_IDLE: begin
          cycle_r <= 5'h00;
        end
        ST_CONVERT: begin
          if (conv_end) begin
            cycle_r <= 5'h00;
            if (!conv_status_control_r[CONT_BIT]) begin
              state_r <= ST_IDLE;
            end // else keep converting
          end else if (tick) begin
            cycle_r <= cycle_r + 5'h01;
          end
        end
        default: begin
          state_r <= ST_IDLE;
          cycle_r <= 5'h00;
        end
      endcase
    end
  end

  // Result registers load only at conversion end; bus writes ignored
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      conv_result_high_r <= 8'h00;
      conv_result_low_r <= 8'h00;
    end else if (conv_end) begin
      conv_result_high_r <= high_nxt;
      conv_result_low_r <= low_nxt;
    end
  end

  // Done flag: completion wins over a result-read clear in the same cycle; a status/control write wins over completion
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      conversion_done_flag_r <= 1'b0;
    end else if (conv_end && !sc_write) begin
      conversion_done_flag_r <= 1'b1;
    end else if (sc_write) begin
      conversion_done_flag_r <= 1'b0;
    end else if (result_read) begin
      conversion_done_flag_r <= 1'b0;
    end
  end

  // Interrupt request follows the flag while enabled
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      conv_irq <= 1'b0;
    end else begin
      conv_irq <= conversion_done_flag_r && conv_status_control_r[IRQ_EN_BIT] && !sc_write;
    end
  end

  // Read data, one cycle after the strobe
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        ADDR_STATUS_CONTROL: reg_rdata <= {conversion_done_flag_r, conv_status_control_r[6:0]};
        ADDR_RESULT_HIGH: reg_rdata <= conv_result_high_r;
        ADDR_RESULT_LOW: reg_rdata <= conv_result_low_r;
        ADDR_PIN_ENABLE: reg_rdata <= conv_pin_enable_r;
        ADDR_CONTROL: reg_rdata <= conv_control_reg_r;
        default: reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // Checks
  sequence s_write_sc;
    sc_write;
  endsequence

  AST_WRITE_CLEARS_FLAG: assert property (@(posedge clk) disable iff (rst)
    s_write_sc |=> !conversion_done_flag_r)
    else $error("done flag not cleared by status/control write");
  AST_WRITE_STARTS: assert property (@(posedge clk) disable iff (rst)
    s_write_sc |=> state_r == ST_CONVERT)
    else $error("write did not start conversion");
  AST_FLAG_SET: assert property (@(posedge clk) disable iff (rst)
    conv_end && !sc_write |=> conversion_done_flag_r)
    else $error("done flag not set at end");
  AST_READ_CLEARS: assert property (@(posedge clk) disable iff (rst)
    result_read && !conv_end && !sc_write |=> !conversion_done_flag_r)
    else $error("result read did not clear flag");
  AST_IRQ: assert property (@(posedge clk) disable iff (rst)
    conv_irq |-> $past(conversion_done_flag_r) && $past(conv_status_control_r[IRQ_EN_BIT]))
    else $error("irq without flag and enable");
  AST_SINGLE_STOPS: assert property (@(posedge clk) disable iff (rst)
    conv_end && !conv_status_control_r[CONT_BIT] && !sc_write && !pe_write |=> state_r == ST_IDLE)
    else $error("single mode did not stop");
  AST_CONT_RUNS: assert property (@(posedge clk) disable iff (rst)
    conv_end && conv_status_control_r[CONT_BIT] && !pe_write |=> state_r == ST_CONVERT)
    else $error("continuous mode stopped");
  AST_ABORT: assert property (@(posedge clk) disable iff (rst)
    pe_write && !sc_write |=> state_r == ST_IDLE)
    else $error("pin-enable write did not abort");
  AST_EIGHT_LOW_ZERO: assert property (@(posedge clk) disable iff (rst)
    conv_end && eight_bit_select |=> conv_result_low_r == 8'h00)
    else $error("eight-bit low result not zero");
  AST_RESULT_STABLE: assert property (@(posedge clk) disable iff (rst)
    !$past(conv_end) |-> $stable(conv_result_high_r) && $stable(conv_result_low_r))
    else $error("result changed without conversion end");

  // Completion that is not overridden by a restart in the same cycle
  sequence s_conv_finish;
    conv_end && !sc_write;
  endsequence

  // Flag standing with the request enabled and no restart under way
  sequence s_flag_armed;
    conversion_done_flag_r && conv_status_control_r[IRQ_EN_BIT] && !sc_write;
  endsequence

  // A write to status/control withdraws any pending request at once
  AST_WRITE_DROPS_IRQ: assert property (@(posedge clk) disable iff (rst)
    s_write_sc |=> !conv_irq)
    else $error("request survived status/control write");
  // A standing, enabled flag shows as a request one cycle later
  AST_IRQ_RAISED: assert property (@(posedge clk) disable iff (rst)
    s_flag_armed |=> conv_irq)
    else $error("request missing while flag set and enabled");
  // The flag rises only at the edge that ends a conversion
  AST_FLAG_ONLY_AT_END: assert property (@(posedge clk) disable iff (rst)
    $rose(conversion_done_flag_r) |-> $past(conv_end))
    else $error("done flag rose without conversion end");
  // Aborting leaves the done flag where it was
  AST_ABORT_KEEPS_FLAG: assert property (@(posedge clk) disable iff (rst)
    pe_write && !conv_end |=> $stable(conversion_done_flag_r))
    else $error("pin-enable write changed the done flag");
  // Low reference, unsigned, always loads an all-zero result
  AST_LOW_REF_ZERO: assert property (@(posedge clk) disable iff (rst)
    s_conv_finish ##0 conv_mux_sel == MUX_REF_LOW && !signed_select
    |=> conv_result_high_r == 8'h00 && conv_result_low_r == 8'h00)
    else $error("low reference result not zero");
  // Left justified, unsigned ten-bit: code in high 7-0 and low 7-6
  AST_LEFT_MAP: assert property (@(posedge clk) disable iff (rst)
    s_conv_finish ##0 !eight_bit_select && !justify_select && !signed_select
    |=> {conv_result_high_r, conv_result_low_r[7:6]} == $past(code_eff))
    else $error("left justified placement wrong");
  // Right justified ten-bit: code in high 1-0 and low 7-0
  AST_RIGHT_MAP: assert property (@(posedge clk) disable iff (rst)
    s_conv_finish ##0 !eight_bit_select && justify_select
    |=> {conv_result_high_r[1:0], conv_result_low_r} == $past(code_eff))
    else $error("right justified placement wrong");
  // Ten-bit padding bits read zero in either justification
  AST_TEN_PAD_ZERO: assert property (@(posedge clk) disable iff (rst)
    s_conv_finish ##0 !eight_bit_select
    |=> $past(justify_select) ? conv_result_high_r[7:2] == 6'h00 : conv_result_low_r[5:0] == 6'h00)
    else $error("ten-bit padding not zero");
  // Eight-bit, unsigned: code bits 9-2 in the high register
  AST_EIGHT_MAP: assert property (@(posedge clk) disable iff (rst)
    s_conv_finish ##0 eight_bit_select && !signed_select
    |=> conv_result_high_r == $past(code_eff[9:2]))
    else $error("eight-bit placement wrong");
  // Signed and left justified: the top result bit is inverted
  AST_SIGNED_MSB: assert property (@(posedge clk) disable iff (rst)
    s_conv_finish ##0 signed_select && !justify_select
    |=> conv_result_high_r[7] == !$past(code_eff[9]))
    else $error("signed msb not inverted");
endmodule

// file: adcr_core_model.sv
/*
  Behavioural analog core: samples the steered input at each conversion
  start and holds the code until the next start.
  Assumes the control unit pulses conv_sample once per conversion.
*/
`timescale 1ns/1ps
module adcr_core_model
  import adcr_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Steering from the control unit
  input wire logic conv_sample,
  input wire logic [1:0] conv_mux_sel,
  input wire logic [2:0] conv_pin_sel,
  // Levels on the eight input pins, pin 0 in the low ten bits
  input wire logic [79:0] pin_levels,
  // Converted code
  output logic [9:0] conv_code
);
  // Captures the steered level; a junk pattern before the first sample
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      conv_code <= 10'h2aa;
    end else if (conv_sample) begin
      case (conv_mux_sel)
        MUX_PIN: conv_code <= pin_levels[conv_pin_sel * 10 +: 10];
        MUX_REF_HIGH: conv_code <= 10'h3ff;
        default: conv_code <= 10'h000;
      endcase
    end
  end
endmodule

// file: adc_control_result_unit_tb_top.sv
/*
  Self-checking bench for the converter control and result unit.
  Assumes the behavioural core model and a 100 MHz clock.
*/
`timescale 1ns/1ps
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin errors++; \
  $display("unexpected %s exp %h got %h", nm, e, g); end end
module adc_control_result_unit_tb_top;
  import adcr_pkg::*;
  logic clk, rst, reg_wr, reg_rd, conv_irq, conv_sample;
  logic [2:0] reg_addr, conv_pin_sel;
  logic [7:0] reg_wdata, reg_rdata, rd_v, ctrl, pe;
  logic [1:0] conv_mux_sel;
  logic [9:0] conv_code;
  logic [79:0] lvl;
  logic [15:0] ex;
  int errors = 0;
  int num_checks = 0;
  int seed;
  adcr_top u_dut (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .conv_irq(conv_irq),
    .conv_sample(conv_sample), .conv_mux_sel(conv_mux_sel),
    .conv_pin_sel(conv_pin_sel), .conv_code(conv_code));
  adcr_core_model u_core (.clk(clk), .rst(rst), .conv_sample(conv_sample),
    .conv_mux_sel(conv_mux_sel), .conv_pin_sel(conv_pin_sel), .pin_levels(lvl),
    .conv_code(conv_code));
  // Bus clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Register port cycles
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 rd_v = reg_rdata;
  endtask
  // Bounded wait for the request
  task automatic wait_irq();
    int n;
    n = 0;
    while (conv_irq !== 1'b1 && n < 400) begin
      @(negedge clk);
      n++;
    end
    `CHK("irq", 1'b1, conv_irq)
  endtask
  // Result placement for a code under a control setting
  function automatic logic [15:0] fmt(input logic [9:0] c, input logic [7:0] k);
    logic [15:0] r;
    if (k[EIGHT_BIT_POS]) r = {c[9:2], 8'h00};
    else if (k[JUSTIFY_POS]) r = {6'h00, c};
    else r = {c, 6'h00};
    if (k[SIGNED_POS] && !k[JUSTIFY_POS]) r[15] = ~r[15];
    return r;
  endfunction
  // Code the core should see for a channel
  function automatic logic [9:0] pick(input logic [4:0] ch);
    if (ch == CHAN_REF_HIGH) return 10'h3ff;
    if (ch <= CHAN_LAST_PIN && pe[ch[2:0]]) return lvl[ch[2:0] * 10 +: 10];
    return 10'h000;
  endfunction
  // Analog mux setting expected for a channel
  function automatic logic [1:0] mux_of(input logic [4:0] ch);
    if (ch == CHAN_REF_HIGH) return MUX_REF_HIGH;
    if (ch <= CHAN_LAST_PIN && pe[ch[2:0]]) return MUX_PIN;
    return MUX_REF_LOW;
  endfunction
  task automatic chk_res(input logic [15:0] e);
    rd(ADDR_RESULT_HIGH);
    `CHK("result high", e[15:8], rd_v)
    rd(ADDR_RESULT_LOW);
    `CHK("result low", e[7:0], rd_v)
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // Watchdog against a hang
  initial begin
    #500000;
    errors++;
    tally_and_finish();
  end
  // Main sequence
  initial begin
    seed = $urandom(50639);
    rst = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 3'h0;
    reg_wdata = 8'h00;
    lvl = '0;
    pe = 8'h00;
    ctrl = 8'h00;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    rd(ADDR_STATUS_CONTROL);
    `CHK("sc reset", STATUS_CONTROL_RST, rd_v)
    rd(ADDR_PIN_ENABLE);
    `CHK("pe reset", PIN_ENABLE_RST, rd_v)
    rd(ADDR_CONTROL);
    `CHK("ctrl reset", CONTROL_RST, rd_v)
    rd(3'h7);
    `CHK("unmapped", 8'h00, rd_v)
    $display("test reset values done");
    // Every channel code, random format, enables and levels
    for (int ch = 0; ch < 32; ch++) begin
      ctrl = 8'($urandom) & 8'h73;
      pe = 8'($urandom);
      lvl = 80'({$urandom, $urandom, $urandom});
      if (ch == 0) lvl[9:0] = 10'h200;
      wr(ADDR_CONTROL, ctrl);
      wr(ADDR_PIN_ENABLE, pe);
      rd(ADDR_PIN_ENABLE);
      `CHK("pe", pe, rd_v)
      wr(ADDR_STATUS_CONTROL, 8'h40 | 8'(ch));
      wait_irq();
      `CHK("mux", mux_of(5'(ch)), conv_mux_sel)
      `CHK("pin", 3'(ch), conv_pin_sel)
      rd(ADDR_STATUS_CONTROL);
      `CHK("sc done", 8'hc0 | 8'(ch), rd_v)
      ex = fmt(pick(5'(ch)), ctrl);
      chk_res(ex);
      rd(ADDR_STATUS_CONTROL);
      `CHK("flag after read", 1'b0, rd_v[DONE_BIT])
      `CHK("irq after read", 1'b0, conv_irq)
      wr(ADDR_RESULT_HIGH, ~ex[15:8]);
      wr(ADDR_RESULT_LOW, ~ex[7:0]);
      chk_res(ex);
    end
    $display("test channels and formats done");
    // Conversion length: slowest divider first, then a random one
    for (int i = 0; i < 2; i++) begin
      ctrl = (i == 0) ? 8'h0f : (8'($urandom) & 8'h7f); // Slowest clock the divider allows
      wr(ADDR_CONTROL, ctrl);
      wr(ADDR_STATUS_CONTROL, 8'h40);
      repeat (2 * (int'(ctrl[3:0]) + 1) * int'(CONV_CYCLES)) @(posedge clk);
      @(negedge clk);
      `CHK("irq early", 1'b0, conv_irq)
      @(negedge clk);
      `CHK("irq on time", 1'b1, conv_irq)
    end
    $display("test conversion length done");
    pe = 8'hff;
    ctrl = 8'h20;
    wr(ADDR_PIN_ENABLE, pe);
    wr(ADDR_CONTROL, ctrl);
    wr(ADDR_STATUS_CONTROL, 8'h40);
    wait_irq();
    wr(ADDR_STATUS_CONTROL, 8'h00);
    rd(ADDR_STATUS_CONTROL);
    `CHK("flag after sc write", 8'h00, rd_v)
    `CHK("irq after sc write", 1'b0, conv_irq)
    repeat (60) @(posedge clk);
    rd(ADDR_STATUS_CONTROL);
    `CHK("fresh conversion", 8'h80, rd_v)
    `CHK("irq disabled", 1'b0, conv_irq)
    chk_res(fmt(pick(5'h00), ctrl));
    repeat (100) @(posedge clk);
    rd(ADDR_STATUS_CONTROL);
    `CHK("single stops", 8'h00, rd_v)
    $display("test restart and single mode done");
    wr(ADDR_STATUS_CONTROL, 8'h40);
    repeat (10) @(posedge clk);
    wr(ADDR_PIN_ENABLE, pe);
    repeat (100) @(posedge clk);
    `CHK("irq after abort", 1'b0, conv_irq)
    rd(ADDR_STATUS_CONTROL);
    `CHK("sc after abort", 8'h40, rd_v)
    $display("test abort done");
    lvl[9:0] <= 10'h155;
    wr(ADDR_STATUS_CONTROL, 8'h60);
    repeat (10) @(posedge clk);
    lvl[9:0] <= 10'h2aa;
    wait_irq();
    chk_res(fmt(10'h155, ctrl));
    wait_irq();
    chk_res(fmt(10'h2aa, ctrl));
    $display("test continuous done");
    wait_irq();
    @(posedge clk);
    rst <= 1'b1;
    @(negedge clk);
    `CHK("irq in reset", 1'b0, conv_irq)
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd(ADDR_STATUS_CONTROL);
    `CHK("sc after reset", STATUS_CONTROL_RST, rd_v)
    `CHK("irq after reset", 1'b0, conv_irq)
    $display("test reset clears request done");
    tally_and_finish();
  end
endmodule
